// ==== logic/dsc_host_clk.sv ====
// Host strobes, pointer, reset, DMA requests and clocking of a dual channel
`timescale 1ns/10ps
module dsc_host_clk
    import dsc_pkg::*;
#(
    parameter int CHANNELS = DSC_CHANNELS,
    parameter int RX_DEPTH = DSC_RX_DEPTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Host bus pins
    input wire logic i_address_strobe_n,
    input wire logic i_chip_sel_n,
    input wire logic i_write_n,
    input wire logic i_int_ack_n,
    input wire logic i_chan_b,
    input wire logic i_data_ctrl,
    input wire logic [7:0] i_data,
    // Channel events and serial clock pins
    input wire logic [CHANNELS-1:0] i_ext_status,
    input wire logic [CHANNELS-1:0] i_rx_tx_clock_pin,
    input wire logic [CHANNELS-1:0] i_xtal_clk,
    input wire logic [CHANNELS-1:0] i_rx_char,
    input wire logic [CHANNELS-1:0] i_rx_read,
    input wire logic [CHANNELS-1:0] i_dma_rx_want,
    input wire logic [CHANNELS-1:0] i_dma_tx_want,
    input wire logic [CHANNELS-1:0] i_digital_phase_locked_loop_fm,
    // Status and control outputs
    output logic [3:0] o_reg_ptr,
    output logic [7:0] o_wr_data,
    output logic o_wr_cmd0,
    output logic o_int_ack,
    output logic o_chip_rst,
    output dsc_dma_t [CHANNELS-1:0] o_dma,
    output logic [CHANNELS-1:0] o_interrupt_pending,
    output logic [CHANNELS-1:0] o_xtal_en,
    output logic [CHANNELS-1:0] o_sample,
    output logic [CHANNELS-1:0] o_rx_overrun,
    output logic [CHANNELS-1:0] o_digital_phase_locked_loop_max_hi
);
    localparam int NSYNC = 4 + 3 * CHANNELS;
    logic [NSYNC-1:0] sync1_reg, sync2_reg, sync3_reg;
    logic [NSYNC-1:0] raw;
    logic as_fall, wr_fall, wr_en, ack_now, soft_rst, rst_any;
    logic [CHANNELS-1:0] ext_s, pin_s, xtal_s;
    logic [CHANNELS-1:0] ext_latch_reg, ext_open_reg, ext_pend_reg;
    dsc_clkcfg_t [CHANNELS-1:0] cfg_reg;
    logic [1:0] rx_cnt_reg [CHANNELS];

    assign raw = {i_xtal_clk, i_rx_tx_clock_pin, i_ext_status,
                  i_int_ack_n, i_chip_sel_n, i_write_n, i_address_strobe_n};

    // Two-flop synchronisers, third stage only for edge detection
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            sync3_reg <= '1;
        end else begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign as_fall = !sync2_reg[0] && sync3_reg[0];
    // Combined select/write low edge; data pins assumed stable by then
    assign wr_en = !sync2_reg[1] && !sync2_reg[2];
    assign wr_fall = wr_en && !(!sync3_reg[1] && !sync3_reg[2]);
    assign ack_now = !sync2_reg[3];
    assign ext_s = sync2_reg[4 +: CHANNELS];
    assign pin_s = sync2_reg[4 + CHANNELS +: CHANNELS];
    assign xtal_s = sync2_reg[4 + 2 * CHANNELS +: CHANNELS];

    assign soft_rst = wr_fall && !i_data_ctrl && (o_reg_ptr == DSC_PTR_MIC)
        && (i_data[DSC_MIC_RESET_LSB +: 2] == DSC_MIC_RESET_CODE);
    assign rst_any = soft_rst || o_chip_rst;

    // Reset pulse held for a fixed number of clocks; clears itself
    logic [2:0] rst_cnt_reg;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rst_cnt_reg <= 3'(DSC_RESET_CYCLES);
            o_chip_rst <= 1'b1;
        end else if (soft_rst) begin
            rst_cnt_reg <= 3'(DSC_RESET_CYCLES);
            o_chip_rst <= 1'b1;
        end else if (rst_cnt_reg != 3'h0) begin
            rst_cnt_reg <= rst_cnt_reg - 3'h1;
            o_chip_rst <= (rst_cnt_reg != 3'h1);
        end else begin
            o_chip_rst <= 1'b0;
        end
    end

    // Shared pointer and write latch
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_ptr <= DSC_PTR_CMD0;
            o_wr_data <= 8'h00;
            o_wr_cmd0 <= 1'b0;
        end else if (o_chip_rst) begin
            o_reg_ptr <= DSC_PTR_CMD0;
            o_wr_cmd0 <= 1'b0;
        end else begin
            o_wr_cmd0 <= 1'b0;
            if (wr_fall) begin
                o_wr_data <= i_data;
                if (i_data_ctrl) begin
                    o_reg_ptr <= DSC_PTR_CMD0;
                end else if (o_reg_ptr == DSC_PTR_CMD0) begin
                    o_wr_cmd0 <= 1'b1;
                    o_reg_ptr <= i_data[DSC_CMD0_PTR_LSB +: 4];
                end else begin
                    o_reg_ptr <= DSC_PTR_CMD0;
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_int_ack <= 1'b0;
        end else begin
            o_int_ack <= ack_now;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            logic sel, reset_ext;
            assign sel = (i_chan_b == 1'(g));
            assign reset_ext = wr_fall && !i_data_ctrl && sel
                && (o_reg_ptr == DSC_PTR_CMD0)
                && (i_data[DSC_CMD0_CMD_LSB +: 3] == DSC_CMD0_RESET_EXT);

            always_ff @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    cfg_reg[g] <= '0;
                end else if (wr_fall && !i_data_ctrl && sel) begin
                    case (o_reg_ptr)
                        DSC_PTR_CLKMODE: begin
                            cfg_reg[g].xtal_en <=
                                i_data[DSC_CLKMODE_XTAL_BIT];
                            cfg_reg[g].clk_src <= i_data[1:0];
                        end
                        DSC_PTR_TC_LO: cfg_reg[g].time_constant[7:0] <= i_data;
                        DSC_PTR_TC_HI: cfg_reg[g].time_constant[15:8] <= i_data;
                        default: cfg_reg[g] <= cfg_reg[g];
                    endcase
                end
            end

            // Ext/status latch reopened by reset command; pending on AS only
            always_ff @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    ext_latch_reg[g] <= 1'b0;
                    ext_open_reg[g] <= 1'b1;
                    ext_pend_reg[g] <= 1'b0;
                    o_interrupt_pending[g] <= 1'b0;
                end else if (o_chip_rst) begin
                    ext_open_reg[g] <= 1'b1;
                    ext_pend_reg[g] <= 1'b0;
                    o_interrupt_pending[g] <= 1'b0;
                end else begin
                    if (ext_open_reg[g] && ext_s[g] != ext_latch_reg[g]) begin
                        ext_latch_reg[g] <= ext_s[g];
                        ext_open_reg[g] <= 1'b0;
                        ext_pend_reg[g] <= 1'b1;
                    end else if (reset_ext) begin
                        ext_open_reg[g] <= 1'b1;
                        ext_pend_reg[g] <= 1'b0;
                    end
                    if (as_fall) begin
                        o_interrupt_pending[g] <= ext_pend_reg[g];
                    end
                end
            end

            always_ff @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    o_dma[g] <= '0;
                    o_xtal_en[g] <= 1'b0;
                    o_digital_phase_locked_loop_max_hi[g] <= 1'b0;
                end else begin
                    o_dma[g].rx_req <= i_dma_rx_want[g] && !o_chip_rst;
                    o_dma[g].tx_req <= i_dma_tx_want[g] && !o_chip_rst;
                    o_xtal_en[g] <= cfg_reg[g].xtal_en;
                    o_digital_phase_locked_loop_max_hi[g] <= i_digital_phase_locked_loop_fm[g];
                end
            end

            // Receive buffer fill count; overrun on arrival when full
            always_ff @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    rx_cnt_reg[g] <= 2'h0;
                    o_rx_overrun[g] <= 1'b0;
                end else if (o_chip_rst) begin
                    rx_cnt_reg[g] <= 2'h0;
                    o_rx_overrun[g] <= 1'b0;
                end else begin
                    if (i_rx_char[g] && !i_rx_read[g]
                        && rx_cnt_reg[g] == 2'(RX_DEPTH)) begin
                        o_rx_overrun[g] <= 1'b1;
                    end
                    if (i_rx_char[g] && !i_rx_read[g]
                        && rx_cnt_reg[g] != 2'(RX_DEPTH)) begin
                        rx_cnt_reg[g] <= rx_cnt_reg[g] + 2'h1;
                    end else if (!i_rx_char[g] && i_rx_read[g]
                        && rx_cnt_reg[g] != 2'h0) begin
                        rx_cnt_reg[g] <= rx_cnt_reg[g] - 2'h1;
                    end
                end
            end

            dsc_brg #(.TC_WIDTH(DSC_TC_WIDTH)) u_brg (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_soft_rst(o_chip_rst),
                .i_tc(cfg_reg[g].time_constant),
                .i_src(cfg_reg[g].clk_src),
                .i_pin_clk(pin_s[g]),
                .i_xtal_clk(xtal_s[g]),
                .o_tick(),
                .o_sample(o_sample[g])
            );

            a_ip_on_as: assert property (@(posedge i_clk) disable iff (i_sys_rst)
                (!as_fall && !o_chip_rst) |=> $stable(o_interrupt_pending[g]))
                else $error("pending changed without address strobe");
            a_xtal_follow: assert property (@(posedge i_clk)
                disable iff (i_sys_rst)
                ##1 o_xtal_en[g] == $past(cfg_reg[g].xtal_en))
                else $error("crystal enable does not follow bit 7");
            a_dma_indep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
                (i_dma_rx_want[g] && i_dma_tx_want[g] && !o_chip_rst)
                |=> (o_dma[g].rx_req && o_dma[g].tx_req))
                else $error("rx and tx requests not independent");
            a_ext_reopen: assert property (@(posedge i_clk)
                disable iff (i_sys_rst)
                (reset_ext && !o_chip_rst && !(ext_open_reg[g]
                 && ext_s[g] != ext_latch_reg[g])) |=> ext_open_reg[g])
                else $error("reset command did not reopen latch");
            a_overrun_full: assert property (@(posedge i_clk)
                disable iff (i_sys_rst)
                (!o_chip_rst && i_rx_char[g] && !i_rx_read[g]
                 && rx_cnt_reg[g] == 2'(RX_DEPTH)) |=> o_rx_overrun[g])
                else $error("overrun not flagged when full");
        end
    endgenerate

    sequence s_soft_cmd;
        soft_rst;
    endsequence
    sequence s_rst_hold;
        o_chip_rst [*4] ##1 !o_chip_rst;
    endsequence
    a_soft_reset: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_soft_cmd |=> s_rst_hold)
        else $error("soft reset not held four clocks");
    a_rst_selfclr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (o_chip_rst && !soft_rst) |-> ##[1:4] !o_chip_rst)
        else $error("reset did not clear itself");
    a_ptr_return: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_fall && !o_chip_rst && !soft_rst && o_reg_ptr != DSC_PTR_CMD0)
        |=> o_reg_ptr == DSC_PTR_CMD0)
        else $error("pointer did not return to zero");
    a_wr_latch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_fall && !o_chip_rst) |=> o_wr_data == $past(i_data))
        else $error("write data not latched");
    a_ack_any_cs: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ack_now |=> o_int_ack)
        else $error("acknowledge ignored");
    a_both_dma: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (&i_dma_rx_want && !o_chip_rst) |=> (o_dma[0].rx_req && o_dma[1].rx_req))
        else $error("channels interlocked");
endmodule

// ==== logic/dsc_pkg.sv ====
// Shared constants and carrier types for the dual serial host/clocking block
package dsc_pkg;
    localparam int DSC_CHANNELS = 2;
    localparam int DSC_SYNC_STAGES = 2;
    localparam int DSC_RESET_CYCLES = 4;
    localparam int DSC_TC_WIDTH = 16;
    localparam int DSC_RX_DEPTH = 3;
    localparam logic [3:0] DSC_PTR_CMD0 = 4'h0;
    localparam logic [3:0] DSC_PTR_MIC = 4'h9;
    localparam logic [3:0] DSC_PTR_CLKMODE = 4'hB;
    localparam logic [3:0] DSC_PTR_TC_LO = 4'hC;
    localparam logic [3:0] DSC_PTR_TC_HI = 4'hD;
    localparam logic [1:0] DSC_MIC_RESET_CODE = 2'h3;
    localparam int DSC_MIC_RESET_LSB = 6;
    localparam int DSC_CLKMODE_XTAL_BIT = 7;
    localparam int DSC_CMD0_PTR_LSB = 0;
    localparam logic [2:0] DSC_CMD0_RESET_EXT = 3'h2;
    localparam int DSC_CMD0_CMD_LSB = 3;
    localparam logic [3:0] DSC_SAMPLE_COUNT = 4'h8;
    localparam logic [4:0] DSC_DIGITAL_PHASE_LOCKED_LOOP_FM_DIV = 5'h10;
    localparam logic [5:0] DSC_DIGITAL_PHASE_LOCKED_LOOP_NRZ_DIV = 6'h20;
    localparam logic [1:0] DSC_SRC_PIN = 2'h0;
    localparam logic [1:0] DSC_SRC_PCLK = 2'h1;
    localparam logic [1:0] DSC_SRC_XTAL = 2'h2;

    typedef struct packed {
        logic rx_req;
        logic tx_req;
    } dsc_dma_t;

    typedef struct packed {
        logic [DSC_TC_WIDTH-1:0] time_constant;
        logic [1:0] clk_src;
        logic xtal_en;
    } dsc_clkcfg_t;
endpackage

// ==== logic/dsc_brg.sv ====
// Bit-rate generator for one channel with 16x mid-cell sample strobe
`timescale 1ns/10ps
module dsc_brg
    import dsc_pkg::*;
#(
    parameter int TC_WIDTH = DSC_TC_WIDTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_soft_rst,
    // Configuration and clock sources
    input wire logic [TC_WIDTH-1:0] i_tc,
    input wire logic [1:0] i_src,
    input wire logic i_pin_clk,
    input wire logic i_xtal_clk,
    // Outputs
    output logic o_tick,
    output logic o_sample
);
    logic [TC_WIDTH-1:0] cnt_reg;
    logic [3:0] cell_reg;
    logic src_en;

    // Source levels are synchronous already; pick one as a count enable
    always_comb begin
        case (i_src)
            DSC_SRC_PIN: src_en = i_pin_clk;
            DSC_SRC_PCLK: src_en = 1'b1;
            DSC_SRC_XTAL: src_en = i_xtal_clk;
            default: src_en = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_reg <= '0;
            o_tick <= 1'b0;
        end else if (i_soft_rst) begin
            cnt_reg <= i_tc;
            o_tick <= 1'b0;
        end else if (src_en) begin
            o_tick <= (cnt_reg == '0);
            if (cnt_reg == '0) begin
                cnt_reg <= i_tc;
            end else begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end else begin
            o_tick <= 1'b0;
        end
    end

    // Cell counter: 16 ticks per bit, sample at count 8
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cell_reg <= '0;
            o_sample <= 1'b0;
        end else if (i_soft_rst) begin
            cell_reg <= '0;
            o_sample <= 1'b0;
        end else begin
            o_sample <= o_tick && (cell_reg == DSC_SAMPLE_COUNT);
            if (o_tick) begin
                cell_reg <= cell_reg + 4'h1;
            end
        end
    end

    a_reload_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!i_soft_rst && src_en && cnt_reg == '0) |=> (cnt_reg == $past(i_tc)))
        else $error("counter did not reload at zero");
    a_soft_reload: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_soft_rst |=> (cnt_reg == $past(i_tc) && !o_tick))
        else $error("counter did not reload on soft reset");
    a_sample_mid: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_sample |-> ($past(cell_reg) == DSC_SAMPLE_COUNT))
        else $error("sample not at cell count 8");
endmodule

// ==== sim/dsc_host_model.sv ====
// Host processor model driving the parallel bus pins of the block
`timescale 1ns/10ps
module dsc_host_model (
    // Clock
    input wire logic i_clk,
    // Host bus pins
    output logic o_address_strobe_n,
    output logic o_chip_sel_n,
    output logic o_write_n,
    output logic o_int_ack_n,
    output logic o_chan_b,
    output logic o_data_ctrl,
    output logic [7:0] o_data
);
    logic as_run;
    logic [1:0] as_cnt;

    initial begin
        as_run = 1'b1;
        as_cnt = 2'h0;
        o_address_strobe_n = 1'b1;
        o_chip_sel_n = 1'b1;
        o_write_n = 1'b1;
        o_int_ack_n = 1'b1;
        o_chan_b = 1'b0;
        o_data_ctrl = 1'b0;
        o_data = 8'h00;
    end

    // Strobe runs free so pending bits keep updating
    always @(posedge i_clk) begin
        #1;
        as_cnt <= as_cnt + 2'h1;
        o_address_strobe_n <= ~(as_run & as_cnt[1]);
    end

    // Pins held four clocks: strobes are synchronised, not sampled
    task automatic wr(input logic ch, input logic dat, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_chan_b = ch;
        o_data_ctrl = dat;
        o_data = d;
        o_chip_sel_n = 1'b0;
        o_write_n = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        o_chip_sel_n = 1'b1;
        o_write_n = 1'b1;
        // Released bus must not keep showing the written byte
        o_data = ~d;
        repeat (5) @(posedge i_clk);
        // Return off the edge so callers never race the design's updates
        #1;
    endtask

    // Select level is free during acknowledge; write stays high
    task automatic ack(input logic v, input logic cs);
        @(posedge i_clk);
        #1;
        o_int_ack_n = v;
        o_chip_sel_n = cs;
    endtask
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the dual channel host and clocking block
`timescale 1ns/10ps
module tb;
    import dsc_pkg::*;
    localparam int TC = 20000000 / (2 * 156250 * 16) - 2;
    logic i_clk, i_sys_rst;
    logic as_n, cs_n, wr_n, ack_n, chb, dctl;
    logic [7:0] dat, wr_data;
    logic [1:0] ext, pin, xtal, rxc, rxr, dmr, dmt, fm;
    logic [1:0] pend, xen, smp, ovr, dmax;
    logic [3:0] reg_ptr;
    logic wr_cmd0, int_ack, chip_rst;
    dsc_dma_t [1:0] dma;
    int num_errors, samples_checked, n_cmd0, n_rst;
    int n_smp [2];

    dsc_host_model dsc_host_model_i (.i_clk(i_clk),
        .o_address_strobe_n(as_n), .o_chip_sel_n(cs_n), .o_write_n(wr_n),
        .o_int_ack_n(ack_n), .o_chan_b(chb), .o_data_ctrl(dctl),
        .o_data(dat));

    dsc_host_clk dsc_host_clk_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_address_strobe_n(as_n), .i_chip_sel_n(cs_n), .i_write_n(wr_n),
        .i_int_ack_n(ack_n), .i_chan_b(chb), .i_data_ctrl(dctl),
        .i_data(dat), .i_ext_status(ext), .i_rx_tx_clock_pin(pin),
        .i_xtal_clk(xtal), .i_rx_char(rxc), .i_rx_read(rxr),
        .i_dma_rx_want(dmr), .i_dma_tx_want(dmt), .i_digital_phase_locked_loop_fm(fm),
        .o_reg_ptr(reg_ptr), .o_wr_data(wr_data), .o_wr_cmd0(wr_cmd0),
        .o_int_ack(int_ack), .o_chip_rst(chip_rst), .o_dma(dma),
        .o_interrupt_pending(pend), .o_xtal_en(xen), .o_sample(smp),
        .o_rx_overrun(ovr), .o_digital_phase_locked_loop_max_hi(dmax));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // Pulses are counted here each clock so none is missed; chip_rst adds one per clock held high
    always @(posedge i_clk) begin
        if (wr_cmd0 === 1'b1) n_cmd0++;
        if (chip_rst === 1'b1) n_rst++;
        for (int c = 0; c < 2; c++) if (smp[c] === 1'b1) n_smp[c]++;
    end

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic close_out();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic t_reset();
        int k;
        for (k = 0; k < 20 && chip_rst !== 1'b0; k++) step(1);
        chk(k, DSC_RESET_CYCLES, "reset release time");
        chk(reg_ptr, 0, "pointer after reset");
        chk(dma, 0, "dma after reset");
        step(4);
        $display("reset test done");
    endtask

    task automatic t_ptr();
        dsc_host_model_i.wr(0, 0, 8'h0B);
        chk(reg_ptr, 4'hB, "pointer load");
        dsc_host_model_i.wr(1, 0, 8'h80);
        chk(reg_ptr, 0, "pointer return");
        chk(xen, 2'b10, "crystal enable");
        dsc_host_model_i.wr(0, 1, 8'h5A);
        chk(wr_data, 8'h5A, "latched data");
        n_cmd0 = 0;
        dsc_host_model_i.wr(1, 0, 8'h00);
        chk(n_cmd0, 1, "command zero pulse");
        $display("pointer test done");
    endtask

    task automatic t_ack_dma();
        dsc_host_model_i.ack(0, 1);
        step(5);
        chk(int_ack, 1, "ack with select high");
        dsc_host_model_i.ack(1, 1);
        step(5);
        chk(int_ack, 0, "ack release");
        dsc_host_model_i.ack(0, 0);
        step(5);
        chk(int_ack, 1, "ack with select low");
        dsc_host_model_i.ack(1, 1);
        step(5);
        chk(int_ack, 0, "ack release after select low");
        dmr = 2'b11;
        dmt = 2'b11;
        step(3);
        chk(dma, 4'hF, "all requests");
        dmt = 2'b00;
        step(3);
        chk(dma, 4'hA, "receive only");
        dmr = 2'b00;
        fm = 2'b01;
        step(3);
        chk(dmax, 2'b01, "digital_phase_locked_loop limit");
        fm = 2'b10;
        step(3);
        chk(dmax, 2'b10, "digital_phase_locked_loop limit swap");
        $display("ack and dma test done");
    endtask

    task automatic t_ovr();
        for (int i = 0; i < 4; i++) begin
            if (i == 3) chk(ovr, 0, "early overrun");
            rxc = 2'b11;
            step(1);
            rxc = 2'b00;
            rxr = 2'b10;
            step(1);
            rxr = 2'b00;
            step(1);
        end
        step(2);
        chk(ovr, 2'b01, "overrun on fourth");
        $display("overrun test done");
    endtask

    task automatic t_brg();
        dsc_host_model_i.wr(0, 0, 8'h0C);
        dsc_host_model_i.wr(0, 0, TC[7:0]);
        dsc_host_model_i.wr(0, 0, 8'h0D);
        dsc_host_model_i.wr(0, 0, 8'h00);
        dsc_host_model_i.wr(0, 0, 8'h0B);
        dsc_host_model_i.wr(0, 0, 8'h01);
        n_smp = '{0, 0};
        step(320);
        chk(n_smp[1], 0, "idle pin source");
        // Cell is 16 ticks of (TC + 1) clocks: 48 clocks, 6 or 7 in the window
        chk(n_smp[0] inside {[6:7]}, 1, "clock source");
        pin = 2'b10;
        n_smp = '{0, 0};
        step(320);
        chk(n_smp[1] inside {[19:20]}, 1, "pin source");
        dsc_host_model_i.wr(0, 0, 8'h0B);
        dsc_host_model_i.wr(1, 0, 8'h82);
        pin = 2'b00;
        xtal = 2'b10;
        n_smp = '{0, 0};
        step(320);
        chk(n_smp[1] inside {[19:20]}, 1, "crystal source");
        $display("bit rate test done");
    endtask

    task automatic t_ext();
        dsc_host_model_i.as_run = 1'b0;
        ext = 2'b01;
        step(12);
        chk(pend, 0, "pending without strobe");
        dsc_host_model_i.as_run = 1'b1;
        step(12);
        chk(pend, 2'b01, "pending on strobe");
        ext = 2'b00;
        dsc_host_model_i.wr(0, 0, 8'h10);
        dsc_host_model_i.wr(0, 0, 8'h10);
        step(8);
        chk(pend, 0, "double latch reset");
        $display("status latch test done");
    endtask

    task automatic t_soft();
        n_rst = 0;
        dsc_host_model_i.wr(0, 0, 8'h09);
        dsc_host_model_i.wr(0, 0, 8'hC0);
        step(6);
        chk(n_rst, 4, "soft reset length");
        chk(reg_ptr, 0, "pointer after soft reset");
        chk(xen, 2'b10, "config kept");
        chk(ovr, 0, "overrun cleared by soft reset");
        $display("soft reset test done");
    endtask

    initial begin
        i_sys_rst = 1'b1;
        {ext, pin, xtal, rxc, rxr, dmr, dmt, fm} = 16'h0000;
        step(16);
        i_sys_rst = 1'b0;
        t_reset();
        t_ptr();
        t_ack_dma();
        t_ovr();
        t_brg();
        t_ext();
        t_soft();
        close_out();
    end

    initial begin
        #(6000 * 50);
        num_errors++;
        close_out();
    end
endmodule
